// ---- logic/esfm_monitor.sv ----
// Purpose: extended-superframe link performance monitor with APB access
// Assumes: link pins are asynchronous; network requests arrive on this clock
// Notes:   long counts are parameters so a bench can shorten them
`timescale 1ns/1ps
`include "esfm_params.svh"

module esfm_monitor #(
  parameter int TICK_CYCLES      = `ESFM_TICK_CYCLES,
  parameter int LOF_CYCLES       = `ESFM_LOF_CYCLES,
  parameter int RED_CLEAR_CYCLES = `ESFM_RED_CLR_CYCLES,
  parameter int INTERVAL_SECS    = `ESFM_INTERVAL_SECS,
  parameter int HOUR_INTERVALS   = `ESFM_HOUR_INTERVALS,
  parameter int DAY_INTERVALS    = `ESFM_DAY_INTERVALS
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic        link_sync_valid,
  input  wire logic        link_sync_err,
  input  wire logic        link_crc_err,
  input  wire logic        link_slip,
  input  wire logic        link_signal_loss,
  input  wire logic        net_stats_reset,
  input  wire logic        net_loopback_req,
  output logic             payload_loop,
  output logic             payload_loop_alarm,
  output logic             frame_loss,
  output logic             unavailable_state,
  output logic             framing_sync_lost,
  output logic             one_second
);

  localparam int NS = `ESFM_NSTATS;

  esfm_pkg::esfm_link_t link_q;
  esfm_pkg::esfm_avail_t avail_reg;
  logic [$bits(esfm_pkg::esfm_link_t)-1:0] link_raw;
  logic [$bits(esfm_pkg::esfm_link_t)-1:0] link_sync;

  logic        lclk_d_reg;
  logic        lrise;
  logic        crc_ev_reg;
  logic        slip_ev_reg;
  logic        oof_ev_reg;
  logic        los_reg;
  logic [3:0]  hist_bits_reg;
  logic [3:0]  hist_bits_next;
  logic [2:0]  bad_cnt;
  logic [31:0] sec_cnt_reg;
  logic [8:0]  crc_sec_reg;
  logic        oof_sec_reg;
  logic        slip_sec_reg;
  logic        lof_sec_reg;
  logic        lof_ev;
  logic [3:0]  run_reg;
  logic [31:0] lof_cnt_reg;
  logic [31:0] err_events_reg;
  logic [31:0] valid_int_reg;
  logic [9:0]  elapsed_reg;
  logic [9:0]  cur_reg   [NS];
  logic [9:0]  new_val   [NS];
  logic [11:0] hour_reg  [NS];
  logic [16:0] day_reg   [NS];
  logic [9:0]  worst_reg [NS];
  logic [9:0]  hist_reg  [DAY_INTERVALS][NS];
  logic [6:0]  wr_idx_reg;
  logic [6:0]  hour_drop;
  logic [6:0]  worst_idx_reg;
  logic        worst_valid_reg;
  logic [31:0] worst_end_reg;
  logic [10:0] new_metric;
  logic [10:0] worst_metric;
  logic        boundary;
  logic        ses_now;
  logic        fdl_perf_reg;
  logic        net_rst_seen_reg;
  logic        clr_stats;
  logic        clr_errev;
  logic        apb_fire;
  logic        wr_fire;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  ofs;

  // Pins are asynchronous: two flops before any use
  assign link_raw = {link_clk, link_sync_valid, link_sync_err, link_crc_err, link_slip,
                     link_signal_loss};

  esfm_sync #(
    .W ($bits(esfm_pkg::esfm_link_t))
  ) u_link_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     (link_raw),
    .q     (link_sync)
  );

  assign link_q = esfm_pkg::esfm_link_t'(link_sync);
  assign lrise  = link_q.lclk & ~lclk_d_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lclk_d_reg  <= 1'b0;
      crc_ev_reg  <= 1'b0;
      slip_ev_reg <= 1'b0;
      los_reg     <= 1'b0;
    end else begin
      lclk_d_reg  <= link_q.lclk;
      crc_ev_reg  <= lrise & link_q.crc_err;
      slip_ev_reg <= lrise & link_q.slip;
      if (lrise) begin
        los_reg <= link_q.signal_loss;
      end
    end
  end

  assign hist_bits_next = {hist_bits_reg[2:0], link_q.sync_err};
  assign bad_cnt = 3'(hist_bits_next[0]) + 3'(hist_bits_next[1]) + 3'(hist_bits_next[2])
                 + 3'(hist_bits_next[3]);

  // two of four sync bits bad
  // Clears only after four good bits in a row, avoiding chatter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hist_bits_reg     <= 4'h0;
      framing_sync_lost <= 1'b0;
      oof_ev_reg        <= 1'b0;
    end else begin
      oof_ev_reg <= 1'b0;
      if (lrise && link_q.sync_valid) begin
        hist_bits_reg <= hist_bits_next;
        if (bad_cnt >= 3'h2) begin
          framing_sync_lost <= 1'b1;
          oof_ev_reg        <= ~framing_sync_lost;
        end else if (bad_cnt == 3'h0) begin
          framing_sync_lost <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_reg <= 32'h0;
      one_second  <= 1'b0;
    end else if (clr_stats || sec_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      sec_cnt_reg <= 32'h0;
      one_second  <= ~clr_stats;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h1;
      one_second  <= 1'b0;
    end
  end

  // per-second counts restart on tick
  // Event in the tick cycle belongs to the new second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      crc_sec_reg  <= 9'h000;
      oof_sec_reg  <= 1'b0;
      slip_sec_reg <= 1'b0;
      lof_sec_reg  <= 1'b0;
    end else if (one_second) begin
      crc_sec_reg  <= {8'h00, crc_ev_reg};
      oof_sec_reg  <= oof_ev_reg | framing_sync_lost;
      slip_sec_reg <= slip_ev_reg;
      lof_sec_reg  <= lof_ev;
    end else begin
      if (crc_ev_reg && crc_sec_reg < `ESFM_SES_CRC_THRESH) begin
        crc_sec_reg <= crc_sec_reg + 9'h001;
      end
      oof_sec_reg  <= oof_sec_reg | oof_ev_reg | framing_sync_lost;
      slip_sec_reg <= slip_sec_reg | slip_ev_reg;
      lof_sec_reg  <= lof_sec_reg | lof_ev;
    end
  end

  // severe on 320 CRC or sync loss
  // Sync loss level, not just its onset, marks each second
  assign ses_now = (crc_sec_reg >= `ESFM_SES_CRC_THRESH) | oof_sec_reg;

  always_comb begin
    for (int i = 0; i < NS; i++) begin
      new_val[i] = cur_reg[i];
    end
    // any CRC, sync loss or slip
    new_val[`ESFM_ST_ES]   = cur_reg[`ESFM_ST_ES]
                           + 10'((crc_sec_reg != 9'h000) | oof_sec_reg | slip_sec_reg);
    new_val[`ESFM_ST_BES]  = cur_reg[`ESFM_ST_BES]
                           + 10'((crc_sec_reg > 9'h001) && (crc_sec_reg < `ESFM_SES_CRC_THRESH));
    new_val[`ESFM_ST_SES]  = cur_reg[`ESFM_ST_SES] + 10'(ses_now);
    new_val[`ESFM_ST_UAS]  = cur_reg[`ESFM_ST_UAS]
                           + 10'(avail_reg == esfm_pkg::ESFM_UNAVAILABLE);
    new_val[`ESFM_ST_CSS]  = cur_reg[`ESFM_ST_CSS] + 10'(slip_sec_reg);
    new_val[`ESFM_ST_FRAME_LOSS_COUNT] = cur_reg[`ESFM_ST_FRAME_LOSS_COUNT] + 10'(lof_sec_reg);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avail_reg <= esfm_pkg::ESFM_AVAILABLE;
      run_reg   <= 4'h0;
    end else if (one_second) begin
      case (avail_reg)
        esfm_pkg::ESFM_AVAILABLE: begin
          if (!ses_now) begin
            run_reg <= 4'h0;
          end else if (run_reg + 4'h1 == `ESFM_UST_RUN) begin
            run_reg   <= 4'h0;
            avail_reg <= esfm_pkg::ESFM_UNAVAILABLE;
          end else begin
            run_reg <= run_reg + 4'h1;
          end
        end
        esfm_pkg::ESFM_UNAVAILABLE: begin
          if (ses_now) begin
            run_reg <= 4'h0;
          end else if (run_reg + 4'h1 == `ESFM_UST_RUN) begin
            run_reg   <= 4'h0;
            avail_reg <= esfm_pkg::ESFM_AVAILABLE;
          end else begin
            run_reg <= run_reg + 4'h1;
          end
        end
        default: begin
          avail_reg <= esfm_pkg::ESFM_AVAILABLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unavailable_state <= 1'b0;
    end else begin
      unavailable_state <= (avail_reg == esfm_pkg::ESFM_UNAVAILABLE);
    end
  end

  // declare after 2.5 s bad, clear after 10 s clean
  // One counter times both the bad run and the clean run
  assign lof_ev = !frame_loss && (framing_sync_lost || los_reg)
                && lof_cnt_reg == 32'(LOF_CYCLES - 1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lof_cnt_reg <= 32'h0;
      frame_loss  <= 1'b0;
    end else if (frame_loss == (framing_sync_lost || los_reg)) begin
      lof_cnt_reg <= 32'h0;
    end else if (lof_ev) begin
      lof_cnt_reg <= 32'h0;
      frame_loss  <= 1'b1;
    end else if (frame_loss && lof_cnt_reg == 32'(RED_CLEAR_CYCLES - 1)) begin
      lof_cnt_reg <= 32'h0;
      frame_loss  <= 1'b0;
    end else begin
      lof_cnt_reg <= lof_cnt_reg + 32'h1;
    end
  end

  // local clears refused after network reset
  assign wr_fire   = apb_fire & pwrite & (paddr == `ESFM_OFS_CTRL);
  assign clr_stats = net_stats_reset
                   | (wr_fire & pwdata[`ESFM_CTRL_CLR_STATS] & ~net_rst_seen_reg);
  assign clr_errev = net_stats_reset
                   | (wr_fire & pwdata[`ESFM_CTRL_CLR_ERREV] & ~net_rst_seen_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      net_rst_seen_reg <= 1'b0;
      fdl_perf_reg     <= 1'b0;
    end else begin
      if (net_stats_reset) begin
        net_rst_seen_reg <= 1'b1;
      end
      if (wr_fire) begin
        fdl_perf_reg <= pwdata[`ESFM_CTRL_FDL_PERF];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      err_events_reg <= 32'h0;
    end else if (clr_errev) begin
      err_events_reg <= 32'h0;
    end else if (crc_ev_reg) begin
      err_events_reg <= err_events_reg + 32'h1;
    end
  end

  // payload loopback with indication and alarm
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      payload_loop       <= 1'b0;
      payload_loop_alarm <= 1'b0;
    end else begin
      payload_loop       <= fdl_perf_reg & net_loopback_req;
      payload_loop_alarm <= fdl_perf_reg & net_loopback_req;
    end
  end

  assign boundary  = one_second && elapsed_reg == 10'(INTERVAL_SECS - 1);
  assign hour_drop = (wr_idx_reg >= 7'(HOUR_INTERVALS)) ? wr_idx_reg - 7'(HOUR_INTERVALS)
                   : wr_idx_reg + 7'(DAY_INTERVALS - HOUR_INTERVALS);
  assign new_metric   = {1'b0, new_val[`ESFM_ST_SES]} + {1'b0, new_val[`ESFM_ST_UAS]};
  assign worst_metric = {1'b0, worst_reg[`ESFM_ST_SES]} + {1'b0, worst_reg[`ESFM_ST_UAS]};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      elapsed_reg   <= 10'h000;
      wr_idx_reg    <= 7'h00;
      valid_int_reg <= 32'h0;
      for (int i = 0; i < NS; i++) begin
        cur_reg[i]  <= 10'h000;
        hour_reg[i] <= 12'h000;
        day_reg[i]  <= 17'h00000;
      end
      for (int j = 0; j < DAY_INTERVALS; j++) begin
        for (int i = 0; i < NS; i++) begin
          hist_reg[j][i] <= 10'h000;
        end
      end
    end else if (clr_stats) begin
      elapsed_reg   <= 10'h000;
      wr_idx_reg    <= 7'h00;
      valid_int_reg <= 32'h0;
      for (int i = 0; i < NS; i++) begin
        cur_reg[i]  <= 10'h000;
        hour_reg[i] <= 12'h000;
        day_reg[i]  <= 17'h00000;
      end
      for (int j = 0; j < DAY_INTERVALS; j++) begin
        for (int i = 0; i < NS; i++) begin
          hist_reg[j][i] <= 10'h000;
        end
      end
    end else if (boundary) begin
      elapsed_reg   <= 10'h000;
      wr_idx_reg    <= (wr_idx_reg == 7'(DAY_INTERVALS - 1)) ? 7'h00 : wr_idx_reg + 7'h01;
      valid_int_reg <= valid_int_reg + 32'h1;
      for (int i = 0; i < NS; i++) begin
        cur_reg[i]             <= 10'h000;
        hist_reg[wr_idx_reg][i] <= new_val[i];
        // hour total slides by one interval
        hour_reg[i] <= hour_reg[i] + {2'b00, new_val[i]} - {2'b00, hist_reg[hour_drop][i]};
        // day total drops the slot being overwritten
        day_reg[i]  <= day_reg[i] + {7'h00, new_val[i]} - {7'h00, hist_reg[wr_idx_reg][i]};
      end
    end else if (one_second) begin
      elapsed_reg <= elapsed_reg + 10'h001;
      for (int i = 0; i < NS; i++) begin
        cur_reg[i] <= new_val[i];
      end
    end
  end

  // worst interval by severe plus unavailable seconds
  // Aged-out worst is replaced by the newest, not rescanned
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      worst_valid_reg <= 1'b0;
      worst_idx_reg   <= 7'h00;
      worst_end_reg   <= 32'h0;
      for (int i = 0; i < NS; i++) begin
        worst_reg[i] <= 10'h000;
      end
    end else if (clr_stats) begin
      worst_valid_reg <= 1'b0;
      worst_idx_reg   <= 7'h00;
      worst_end_reg   <= 32'h0;
      for (int i = 0; i < NS; i++) begin
        worst_reg[i] <= 10'h000;
      end
    end else if (boundary && (!worst_valid_reg || new_metric >= worst_metric
                              || worst_idx_reg == wr_idx_reg)) begin
      worst_valid_reg <= 1'b1;
      worst_idx_reg   <= wr_idx_reg;
      worst_end_reg   <= valid_int_reg + 32'h1;
      for (int i = 0; i < NS; i++) begin
        worst_reg[i] <= new_val[i];
      end
    end
  end

  // statistics readable over APB
  assign ofs = paddr;
  always_comb begin
    rdata = 32'h0;
    rerr  = 1'b0;
    if (ofs == `ESFM_OFS_CTRL) begin
      rdata[`ESFM_CTRL_FDL_PERF] = fdl_perf_reg;
    end else if (ofs == `ESFM_OFS_STATUS) begin
      rdata[`ESFM_STAT_UNAVAIL]  = unavailable_state;
      rdata[`ESFM_STAT_OOF]      = framing_sync_lost;
      rdata[`ESFM_STAT_LOF]      = frame_loss;
      rdata[`ESFM_STAT_PAYLOOP]  = payload_loop;
      rdata[`ESFM_STAT_NETRST]   = net_rst_seen_reg;
      rdata[`ESFM_STAT_ELAPSED +: 10] = elapsed_reg;
    end else if (ofs == `ESFM_OFS_ERR_EVENTS) begin
      rdata = err_events_reg;
    end else if (ofs == `ESFM_OFS_VALID_INT) begin
      rdata = valid_int_reg;
    end else if (ofs >= `ESFM_OFS_CUR_BASE && ofs < `ESFM_OFS_HOUR_BASE) begin
      rdata = {22'h0, cur_reg[3'((ofs - `ESFM_OFS_CUR_BASE) >> 2)]};
    end else if (ofs >= `ESFM_OFS_HOUR_BASE && ofs < `ESFM_OFS_DAY_BASE) begin
      rdata = {20'h0, hour_reg[3'((ofs - `ESFM_OFS_HOUR_BASE) >> 2)]};
    end else if (ofs >= `ESFM_OFS_DAY_BASE && ofs < `ESFM_OFS_WORST_BASE) begin
      rdata = {15'h0, day_reg[3'((ofs - `ESFM_OFS_DAY_BASE) >> 2)]};
    end else if (ofs >= `ESFM_OFS_WORST_BASE && ofs < `ESFM_OFS_WORST_END) begin
      rdata = {22'h0, worst_reg[3'((ofs - `ESFM_OFS_WORST_BASE) >> 2)]};
    end else if (ofs == `ESFM_OFS_WORST_END) begin
      rdata = worst_end_reg;
    end else begin
      rerr = 1'b1;
    end
  end

  // One wait state: data is registered on the same edge that raises pready
  assign apb_fire = psel & penable & pready;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= rerr;
        prdata  <= pwrite ? 32'h0 : rdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// ---- shared/esfm_params.svh ----
// Purpose: constants of the link performance monitor
// Assumes: 125 MHz system clock, APB byte addresses
// Notes:   timing counts derive from times in their own units
`ifndef ESFM_PARAMS_SVH
`define ESFM_PARAMS_SVH

`define ESFM_CLK_PERIOD_NS   8
`define ESFM_SECOND_NS       1000000000
`define ESFM_LOF_TIME_MS     2500
`define ESFM_RED_CLEAR_MS    10000
`define ESFM_TICK_CYCLES     (`ESFM_SECOND_NS / `ESFM_CLK_PERIOD_NS)
`define ESFM_LOF_CYCLES      int'((`ESFM_LOF_TIME_MS * 64'd1000000) / `ESFM_CLK_PERIOD_NS)
`define ESFM_RED_CLR_CYCLES  int'((`ESFM_RED_CLEAR_MS * 64'd1000000) / `ESFM_CLK_PERIOD_NS)

`define ESFM_SES_CRC_THRESH  9'h140
`define ESFM_UST_RUN         4'hA
`define ESFM_INTERVAL_SECS   900
`define ESFM_HOUR_INTERVALS  4
`define ESFM_DAY_INTERVALS   96
`define ESFM_NSTATS          6

`define ESFM_ST_ES           0
`define ESFM_ST_BES          1
`define ESFM_ST_SES          2
`define ESFM_ST_UAS          3
`define ESFM_ST_CSS          4
`define ESFM_ST_FRAME_LOSS_COUNT         5

`define ESFM_OFS_CTRL        8'h00
`define ESFM_OFS_STATUS      8'h04
`define ESFM_OFS_ERR_EVENTS  8'h08
`define ESFM_OFS_VALID_INT   8'h0C
`define ESFM_OFS_CUR_BASE    8'h10
`define ESFM_OFS_HOUR_BASE   8'h28
`define ESFM_OFS_DAY_BASE    8'h40
`define ESFM_OFS_WORST_BASE  8'h58
`define ESFM_OFS_WORST_END   8'h70

`define ESFM_CTRL_FDL_PERF   0
`define ESFM_CTRL_CLR_STATS  1
`define ESFM_CTRL_CLR_ERREV  2

`define ESFM_STAT_UNAVAIL    0
`define ESFM_STAT_OOF        1
`define ESFM_STAT_LOF        2
`define ESFM_STAT_PAYLOOP    3
`define ESFM_STAT_NETRST     4
`define ESFM_STAT_ELAPSED    16

`endif

// ---- shared/esfm_pkg.sv ----
// Purpose: types of the link performance monitor
// Assumes: constants live in esfm_params.svh
// Notes:   link struct order matches the synchroniser bundle
package esfm_pkg;

  typedef struct packed {
    logic lclk;
    logic sync_valid;
    logic sync_err;
    logic crc_err;
    logic slip;
    logic signal_loss;
  } esfm_link_t;

  typedef enum logic {
    ESFM_AVAILABLE,
    ESFM_UNAVAILABLE
  } esfm_avail_t;

endpackage

// ---- logic/esfm_sync.sv ----
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module esfm_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ---- sim/esfm_link_model.sv ----
// Purpose: network side driver of the link pins
// Assumes: link clock of 160 ns, running only while a bit is sent
// Notes:   idle flag lines show the inverse of their last value
`timescale 1ns/1ps
module esfm_link_model (
  output esfm_pkg::esfm_link_t lnk
);
  initial lnk = '0;
  // one flag set per bit
  // Flags settle well before the rise; one bit per 160 ns
  task automatic send(input logic [3:0] f);
    #3 lnk[4:1] = f;
    #40 lnk.lclk = 1'b1;
    #80 lnk.lclk = 1'b0;
    lnk[4:1] = ~lnk[4:1];
    #37;
  endtask
endmodule

// ---- sim/esfm_monitor_assertions.sv ----
// Purpose: port-level checks of the link performance monitor
// Assumes: one clock domain, bound to the monitor
// Notes:   slack of a few cycles covers the link synchroniser
`timescale 1ns/1ps
module esfm_monitor_assertions #(
  parameter int TICK_CYCLES = 400,
  parameter int LOF_CYCLES  = 1000
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       link_signal_loss,
  input wire logic       net_stats_reset,
  input wire logic       net_loopback_req,
  input wire logic       payload_loop,
  input wire logic       payload_loop_alarm,
  input wire logic       frame_loss,
  input wire logic       unavailable_state,
  input wire logic       framing_sync_lost,
  input wire logic       one_second
);
  int tick_cnt;
  int bad_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Network reset restarts the tick as well
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 0;
      bad_cnt  <= 0;
    end else begin
      tick_cnt <= (one_second || net_stats_reset) ? 0 : tick_cnt + 1;
      bad_cnt  <= (framing_sync_lost || link_signal_loss) ? bad_cnt + 1 : 0;
    end
  end
  property p_tick_pulse;
    one_second |=> !one_second;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  property p_tick_len;
    one_second |-> tick_cnt >= TICK_CYCLES - 2 && tick_cnt <= TICK_CYCLES;
  endproperty
  a_tick_len: assert property (p_tick_len) else $error("tick spacing wrong");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  property p_ready_wait;
    psel && penable && !$past(penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_slverr;
    pready |-> pslverr == (paddr >= 8'h74);
  endproperty
  a_slverr: assert property (p_slverr) else $error("error response wrong");
  property p_loop_req;
    payload_loop |-> $past(net_loopback_req) && payload_loop_alarm;
  endproperty
  a_loop_req: assert property (p_loop_req) else $error("loop without request");
  property p_lof_time;
    $rose(frame_loss) |-> bad_cnt >= LOF_CYCLES - 8;
  endproperty
  a_lof_time: assert property (p_lof_time) else $error("frame loss too early");
  property p_ust_tick;
    $rose(unavailable_state) |-> $past(one_second) || $past(one_second, 2) || $past(one_second, 3);
  endproperty
  a_ust_tick: assert property (p_ust_tick) else $error("unavailable off tick");
endmodule

// ---- sim/esfm_link_performance_monitor_test.sv ----
// Purpose: self-checking bench of the link performance monitor
// Assumes: short tick and alarm counts set below
// Notes:   reads queue their expectation; a watcher compares on pready
`timescale 1ns/1ps
module esfm_link_performance_monitor_test;
  localparam int TICK = 400;
  localparam int LOFT = 1000;
  logic                 clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, lfsr = 32'hF1D256E5;
  logic                 pready, pslverr, net_stats_reset = 1'b0, net_loopback_req = 1'b0;
  logic                 payload_loop, payload_loop_alarm, frame_loss, unavailable_state;
  logic                 framing_sync_lost, one_second;
  esfm_pkg::esfm_link_t lnk;
  logic [32:0]          exp_q[$];
  logic [31:0]          msk_q[$];
  int                   num_errors = 0, checks_done = 0, cyc = 0, n;
  always #4 clock = ~clock;
  esfm_link_model i_esfm_link_model (.lnk(lnk));
  esfm_monitor #(.TICK_CYCLES(TICK), .LOF_CYCLES(LOFT), .RED_CLEAR_CYCLES(LOFT),
    .INTERVAL_SECS(32)) i_esfm_monitor (
    .clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_clk(lnk.lclk), .link_sync_valid(lnk.sync_valid), .link_sync_err(lnk.sync_err),
    .link_crc_err(lnk.crc_err), .link_slip(lnk.slip), .link_signal_loss(lnk.signal_loss),
    .net_stats_reset, .net_loopback_req, .payload_loop, .payload_loop_alarm, .frame_loss,
    .unavailable_state, .framing_sync_lost, .one_second);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Called just after a rising edge; ends on one too
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, rnd());
  endtask
  task automatic tick(input int t);
    repeat (t) begin
      do begin
        @(posedge clock);
      end while (one_second !== 1'b1);
    end
    repeat (4) @(posedge clock);
  endtask
  task automatic send(input logic [3:0] f);
    i_esfm_link_model.send(f);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 40000) begin
      num_errors++;
      end_of_test();
    end
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      check({pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(8'h10, 33'h0);
    rd(8'h80, 33'h100000000);
    apb(1'b1, 8'h04, rnd());
    rd(8'h04, 33'h0, 32'h1F);
    tick(1);
    send(4'h2);
    tick(1);
    rd(8'h10, 33'h1);
    rd(8'h14, 33'h0);
    n = 2 + (rnd() & 7);
    repeat (n) send(4'h2);
    tick(1);
    rd(8'h14, 33'h1);
    rd(8'h18, 33'h0);
    send(4'h1);
    tick(1);
    rd(8'h20, 33'h1);
    rd(8'h10, 33'h3);
    rd(8'h08, 33'(n + 1));
    apb(1'b1, 8'h00, 32'h4);
    rd(8'h08, 33'h0);
    net_loopback_req <= 1'b1;
    repeat (3) @(posedge clock);
    check({payload_loop, payload_loop_alarm}, 33'h0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clock);
    check({payload_loop, payload_loop_alarm}, 33'h3);
    rd(8'h04, 33'h8, 32'h8);
    net_loopback_req <= 1'b0;
    tick(1);
    send(4'hC);
    repeat (8) @(posedge clock);
    check(framing_sync_lost, 33'h0);
    send(4'h8);
    send(4'hC);
    repeat (8) @(posedge clock);
    check(framing_sync_lost, 33'h1);
    tick(3);
    check(frame_loss, 33'h1);
    rd(8'h24, 33'h1);
    rd(8'h18, 33'h3);
    tick(6);
    check(unavailable_state, 33'h0);
    tick(1);
    check(unavailable_state, 33'h1);
    tick(2);
    rd(8'h1C, 33'h2);
    repeat (4) send(4'h8);
    tick(10);
    check({unavailable_state, frame_loss}, 33'h2);
    tick(1);
    check(unavailable_state, 33'h0);
    net_stats_reset <= 1'b1;
    @(posedge clock);
    net_stats_reset <= 1'b0;
    @(posedge clock);
    rd(8'h18, 33'h0);
    rd(8'h0C, 33'h0);
    rd(8'h04, 33'h10, 32'h03FF001F);
    repeat (n) send(4'h2);
    tick(2);
    apb(1'b1, 8'h00, 32'h6);
    rd(8'h08, 33'(n));
    rd(8'h04, 33'h00020010, 32'h03FF0010);
    rd(8'h10, 33'h1);
    tick(30);
    rd(8'h10, 33'h0);
    rd(8'h04, 33'h0, 32'h03FF0000);
    rd(8'h28, 33'h1);
    rd(8'h44, 33'h1);
    rd(8'h58, 33'h1);
    rd(8'h70, 33'h1);
    rd(8'h0C, 33'h1);
    end_of_test();
  end
endmodule
bind esfm_monitor esfm_monitor_assertions #(
  .TICK_CYCLES(TICK_CYCLES), .LOF_CYCLES(LOF_CYCLES)) i_esfm_monitor_assertions (
  .clock, .nrst, .psel, .penable, .paddr, .pready, .pslverr, .link_signal_loss,
  .net_stats_reset, .net_loopback_req, .payload_loop, .payload_loop_alarm, .frame_loss,
  .unavailable_state, .framing_sync_lost, .one_second);
